// File: logic/synth_cfg_pkg.sv
// Purpose: Constants for the divider and feedback configuration registers
// Assumes: 24-bit serial frame, read/write flag, 7-bit address, 16-bit data
// Notes:   Reserved bits are stored as written and read back unchanged
// Operation
// - Stage two ratio codes 1,2,4,8 give divide 2,4,6,8; code 0 powers down
// - Stage three uses the same code: 1,2,4,8 give 2,4,6,8; 0 is off
// - Stage one divides by three when its bit is set, else by two
// - Each stage has an enable bit; host should clear unused stages
// - Select code 1 uses stage one, 2 stages one-two, 4 all, 0 off
// - Two separate bits enable divider buffers toward output B and output A
// - Feedback prescaler divides by four when its bit is one, else two
// - Twelve-bit integer feedback value in bits 12:1, reset value 27
// - Delay one-hot codes 1,2,4,8,16 give 4,6,8,12,16 cycles; default 2
// - Denominator is 32 bits in two 16-bit halves, each resetting to 1000
// - Fraction formed from 32-bit numerator halves over the denominator
package synth_cfg_pkg;
  localparam int ADDR_W     = 7;
  localparam int DATA_W     = 16;
  localparam int FRAME_BITS = 24;

  localparam logic [6:0] OFF_STAGE_CFG = 7'h23;
  localparam logic [6:0] OFF_SEL_DIST  = 7'h24;
  localparam logic [6:0] OFF_PRESCALE  = 7'h25;
  localparam logic [6:0] OFF_N_INT     = 7'h26;
  localparam logic [6:0] OFF_PHASE_DETECTOR_DELAY_CODE   = 7'h27;
  localparam logic [6:0] OFF_DEN_HI    = 7'h28;
  localparam logic [6:0] OFF_DEN_LO    = 7'h29;
  localparam logic [6:0] OFF_NUM_HI    = 7'h2C;
  localparam logic [6:0] OFF_NUM_LO    = 7'h2D;

  // Field positions
  localparam int STG2_RATIO_LSB = 9;
  localparam int STG3_EN_BIT    = 8;
  localparam int STG2_EN_BIT    = 7;
  localparam int STG1_RATIO_BIT = 2;
  localparam int STG1_EN_BIT    = 1;
  localparam int DIST_B_BIT     = 11;
  localparam int DIST_A_BIT     = 10;
  localparam int SEL_LSB        = 4;
  localparam int STG3_RATIO_LSB = 0;
  localparam int PRESCALE_BIT   = 12;
  localparam int N_INT_LSB      = 1;
  localparam int PHASE_DETECTOR_DELAY_CODE_LSB    = 8;

  // Reset values
  localparam logic [15:0] RST_STAGE_CFG = 16'h0204;
  localparam logic [15:0] RST_SEL_DIST  = 16'h0411;
  localparam logic [15:0] RST_PRESCALE  = 16'h0000;
  localparam logic [15:0] RST_N_INT     = 16'h0036;
  localparam logic [15:0] RST_PHASE_DETECTOR_DELAY_CODE   = 16'h0200;
  localparam logic [15:0] RST_DEN_HALF  = 16'h03E8;
  localparam logic [15:0] RST_NUM_HALF  = 16'h0000;

  // Stage ratio codes and the ratios they give
  localparam logic [3:0] CODE_DIV2 = 4'h1;
  localparam logic [3:0] CODE_DIV4 = 4'h2;
  localparam logic [3:0] CODE_DIV6 = 4'h4;
  localparam logic [3:0] CODE_DIV8 = 4'h8;
  localparam logic [2:0] SEL_ONE   = 3'h1;
  localparam logic [2:0] SEL_TWO   = 3'h2;
  localparam logic [2:0] SEL_THREE = 3'h4;

  // Delay codes and cycle counts
  localparam logic [5:0] DLY_CODE_4  = 6'h01;
  localparam logic [5:0] DLY_CODE_6  = 6'h02;
  localparam logic [5:0] DLY_CODE_8  = 6'h04;
  localparam logic [5:0] DLY_CODE_12 = 6'h08;
  localparam logic [5:0] DLY_CODE_16 = 6'h10;

  typedef enum logic [1:0] {X_IDLE, X_SHIFT, X_DONE} xfer_t;
endpackage

// File: logic/stage_ratio_decode.sv
// Purpose: Decode one four-bit divider stage code into its divide ratio
// Assumes: Ratio 0 means the stage is powered down
// Notes:   Non one-hot codes are treated as power down
`timescale 1ns/1ps
module stage_ratio_decode (
  input  wire logic [3:0] code,
  input  wire logic       enable,
  output logic      [3:0] ratio
);
  import synth_cfg_pkg::*;

  always_comb begin
    ratio = 4'h0;
    if (enable) begin
      case (code)
        CODE_DIV2: ratio = 4'h2;
        CODE_DIV4: ratio = 4'h4;
        CODE_DIV6: ratio = 4'h6;
        CODE_DIV8: ratio = 4'h8;
        default:   ratio = 4'h0;
      endcase
    end
  end
endmodule // stage_ratio_decode

// File: logic/synth_divider_config_regs.sv
// Purpose: Serially programmed divider, feedback and fraction registers
// Assumes: Serial pins are synchronous to ref_clk and sck is far slower
// Notes:   Stage ratio, delay and fraction_valid outputs follow the registers by one clock, chain_ratio by up to two
`timescale 1ns/1ps
module synth_divider_config_regs #(
  parameter int FRAME_LEN = synth_cfg_pkg::FRAME_BITS
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        cs_n,
  input  wire logic        sck,
  input  wire logic        sdi,
  output logic             sdo,
  output logic      [3:0]  stage_one_ratio,
  output logic      [3:0]  stage_two_ratio,
  output logic      [3:0]  stage_three_ratio,
  output logic             stage_one_enable,
  output logic             stage_two_enable,
  output logic             stage_three_enable,
  output logic      [2:0]  stage_select,
  output logic      [7:0]  chain_ratio,
  output logic             divider_to_out_a_buffer_enable,
  output logic             divider_to_out_b_buffer_enable,
  output logic      [2:0]  prescaler_ratio,
  output logic      [11:0] feedback_integer,
  output logic      [4:0]  phase_detector_delay_cycles,
  output logic             phase_detector_delay_valid,
  output logic      [31:0] fraction_numerator,
  output logic      [31:0] fraction_denominator,
  output logic             fraction_valid
);
  import synth_cfg_pkg::*;

  // Shift register and counter are sized for one frame length only
  if (FRAME_LEN != FRAME_BITS) begin : g_bad_frame_len
    $error("FRAME_LEN must equal the 24-bit frame");
  end

  typedef struct packed {
    xfer_t       xs;
    logic        sck_d;
    logic [4:0]  cnt;
    logic [23:0] sh;
    logic [15:0] out_sh;
    logic [15:0] stage_cfg;
    logic [15:0] sel_dist;
    logic [15:0] prescale;
    logic [15:0] n_int;
    logic [15:0] phase_detector_delay_code;
    logic [15:0] den_hi;
    logic [15:0] den_lo;
    logic [15:0] num_hi;
    logic [15:0] num_lo;
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic [3:0]  s3;
    logic [7:0]  chain;
    logic [4:0]  dly;
    logic        dly_ok;
    logic        frac_ok;
  } state_t;

  localparam state_t STATE_RST = '{
    xs: X_IDLE, sck_d: 1'b0, cnt: 5'h00, sh: 24'h000000,
    out_sh: 16'h0000, stage_cfg: RST_STAGE_CFG, sel_dist: RST_SEL_DIST,
    prescale: RST_PRESCALE, n_int: RST_N_INT, phase_detector_delay_code: RST_PHASE_DETECTOR_DELAY_CODE,
    den_hi: RST_DEN_HALF, den_lo: RST_DEN_HALF, num_hi: RST_NUM_HALF,
    num_lo: RST_NUM_HALF, s1: 4'h0, s2: 4'h0, s3: 4'h0, chain: 8'h00,
    dly: 5'h00, dly_ok: 1'b0, frac_ok: 1'b0
  };

  state_t state_r;
  state_t state_nxt;

  logic [3:0] seg_code [2];
  logic       seg_en   [2];
  logic [3:0] seg_ratio[2];
  logic       sck_rise;
  logic [6:0] rd_addr;
  logic [6:0] wr_addr;
  logic [15:0] wr_data;
  logic [31:0] num_full;
  logic [31:0] den_full;

  assign seg_code[0] = state_r.stage_cfg[STG2_RATIO_LSB +: 4];
  assign seg_en[0]   = state_r.stage_cfg[STG2_EN_BIT];
  assign seg_code[1] = state_r.sel_dist[STG3_RATIO_LSB +: 4];
  assign seg_en[1]   = state_r.stage_cfg[STG3_EN_BIT];

  // Stages two and three share one encoding
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_seg
      stage_ratio_decode u_dec (
        .code   (seg_code[g]),
        .enable (seg_en[g]),
        .ratio  (seg_ratio[g])
      );
    end
  endgenerate

  assign sck_rise = sck & ~state_r.sck_d;
  assign rd_addr  = {state_r.sh[5:0], sdi};
  assign wr_addr  = state_r.sh[21:15];
  assign wr_data  = {state_r.sh[14:0], sdi};
  assign num_full = {state_r.num_hi, state_r.num_lo};
  assign den_full = {state_r.den_hi, state_r.den_lo};

  function automatic logic [15:0] read_word(input logic [6:0] a,
                                            input state_t s);
    case (a)
      OFF_STAGE_CFG: read_word = s.stage_cfg;
      OFF_SEL_DIST:  read_word = s.sel_dist;
      OFF_PRESCALE:  read_word = s.prescale;
      OFF_N_INT:     read_word = s.n_int;
      OFF_PHASE_DETECTOR_DELAY_CODE:   read_word = s.phase_detector_delay_code;
      OFF_DEN_HI:    read_word = s.den_hi;
      OFF_DEN_LO:    read_word = s.den_lo;
      OFF_NUM_HI:    read_word = s.num_hi;
      OFF_NUM_LO:    read_word = s.num_lo;
      default:       read_word = 16'h0000;
    endcase
  endfunction

  always_comb begin
    state_nxt       = state_r;
    state_nxt.sck_d = sck;

    // Serial frame: flag, address, data, most significant bit first
    case (state_r.xs)
      X_IDLE: begin
        state_nxt.cnt = 5'h00;
        if (!cs_n) begin
          state_nxt.xs = X_SHIFT;
        end
      end
      X_SHIFT: begin
        if (sck_rise) begin
          state_nxt.sh  = {state_r.sh[22:0], sdi};
          state_nxt.cnt = state_r.cnt + 5'h01;
          if (state_r.cnt == 5'h07) begin
            state_nxt.out_sh = read_word(rd_addr, state_r);
          end else if (state_r.cnt > 5'h07) begin
            state_nxt.out_sh = {state_r.out_sh[14:0], 1'b0};
          end
          if (state_r.cnt == 5'(FRAME_LEN - 1)) begin
            state_nxt.xs = X_DONE;
            // Reserved bits kept as the host wrote them
            if (!state_r.sh[22]) begin
              case (wr_addr)
                OFF_STAGE_CFG: state_nxt.stage_cfg = wr_data;
                OFF_SEL_DIST:  state_nxt.sel_dist  = wr_data;
                OFF_PRESCALE:  state_nxt.prescale  = wr_data;
                OFF_N_INT:     state_nxt.n_int     = wr_data;
                OFF_PHASE_DETECTOR_DELAY_CODE:   state_nxt.phase_detector_delay_code   = wr_data;
                OFF_DEN_HI:    state_nxt.den_hi    = wr_data;
                OFF_DEN_LO:    state_nxt.den_lo    = wr_data;
                OFF_NUM_HI:    state_nxt.num_hi    = wr_data;
                OFF_NUM_LO:    state_nxt.num_lo    = wr_data;
                default:       ;
              endcase
            end
          end
        end
      end
      X_DONE: begin
        // Extra clocks past the frame are ignored
      end
      default: state_nxt.xs = X_IDLE;
    endcase
    if (cs_n) begin
      state_nxt.xs  = X_IDLE;
      state_nxt.cnt = 5'h00;
    end

    // Stage one: three or two, zero when powered down
    if (!state_r.stage_cfg[STG1_EN_BIT]) begin
      state_nxt.s1 = 4'h0;
    end else if (state_r.stage_cfg[STG1_RATIO_BIT]) begin
      state_nxt.s1 = 4'h3;
    end else begin
      state_nxt.s1 = 4'h2;
    end
    state_nxt.s2 = seg_ratio[0];
    state_nxt.s3 = seg_ratio[1];

    // An unpowered included stage forces the whole chain to zero
    case (state_r.sel_dist[SEL_LSB +: 3])
      SEL_ONE:   state_nxt.chain = 8'(state_r.s1);
      SEL_TWO:   state_nxt.chain = 8'(state_r.s1) * 8'(state_r.s2);
      SEL_THREE: state_nxt.chain = 8'(state_r.s1) * 8'(state_r.s2)
                                 * 8'(state_r.s3);
      default:   state_nxt.chain = 8'h00;
    endcase

    state_nxt.dly_ok = 1'b1;
    case (state_r.phase_detector_delay_code[PHASE_DETECTOR_DELAY_CODE_LSB +: 6])
      DLY_CODE_4:  state_nxt.dly = 5'h04;
      DLY_CODE_6:  state_nxt.dly = 5'h06;
      DLY_CODE_8:  state_nxt.dly = 5'h08;
      DLY_CODE_12: state_nxt.dly = 5'h0C;
      DLY_CODE_16: state_nxt.dly = 5'h10;
      default: begin
        state_nxt.dly    = 5'h00;
        state_nxt.dly_ok = 1'b0;
      end
    endcase

    // Zero denominator or numerator not below it is no usable fraction
    state_nxt.frac_ok = (den_full != 32'h00000000) &&
                        (num_full < den_full);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sdo                = state_r.out_sh[15];
  assign stage_one_ratio    = state_r.s1;
  assign stage_two_ratio    = state_r.s2;
  assign stage_three_ratio  = state_r.s3;
  assign stage_one_enable   = state_r.stage_cfg[STG1_EN_BIT];
  assign stage_two_enable   = state_r.stage_cfg[STG2_EN_BIT];
  assign stage_three_enable = state_r.stage_cfg[STG3_EN_BIT];
  assign stage_select       = state_r.sel_dist[SEL_LSB +: 3];
  assign chain_ratio        = state_r.chain;
  assign divider_to_out_a_buffer_enable =
    state_r.sel_dist[DIST_A_BIT];
  assign divider_to_out_b_buffer_enable =
    state_r.sel_dist[DIST_B_BIT];
  assign prescaler_ratio    = state_r.prescale[PRESCALE_BIT] ?
                              3'h4 : 3'h2;
  assign feedback_integer   = state_r.n_int[N_INT_LSB +: 12];
  assign phase_detector_delay_cycles = state_r.dly;
  assign phase_detector_delay_valid  = state_r.dly_ok;
  assign fraction_numerator   = num_full;
  assign fraction_denominator = den_full;
  assign fraction_valid       = state_r.frac_ok;
endmodule // synth_divider_config_regs

// File: tb/synth_cfg_assertions.sv
// Purpose: Port checks on the decoded divider and feedback outputs
// Assumes: One ref_clk domain, rst synchronous active high
// Notes:   Decoding lags registers, so the chain and fraction checks wait for quiet inputs
`timescale 1ns/1ps
module synth_cfg_assertions (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        cs_n,
  input wire logic [3:0]  stage_one_ratio,
  input wire logic [3:0]  stage_two_ratio,
  input wire logic [3:0]  stage_three_ratio,
  input wire logic        stage_one_enable,
  input wire logic [2:0]  stage_select,
  input wire logic [7:0]  chain_ratio,
  input wire logic        divider_to_out_a_buffer_enable,
  input wire logic        divider_to_out_b_buffer_enable,
  input wire logic [2:0]  prescaler_ratio,
  input wire logic [11:0] feedback_integer,
  input wire logic [4:0]  phase_detector_delay_cycles,
  input wire logic        phase_detector_delay_valid,
  input wire logic [31:0] fraction_numerator,
  input wire logic [31:0] fraction_denominator,
  input wire logic        fraction_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] prod;
  always_comb begin
    case (stage_select)
      3'h1:    prod = {4'h0, stage_one_ratio};
      3'h2:    prod = 8'(stage_one_ratio) * 8'(stage_two_ratio);
      3'h4:    prod = 8'(stage_one_ratio) * 8'(stage_two_ratio)
                      * 8'(stage_three_ratio);
      default: prod = 8'h00;
    endcase
  end
  sequence chain_quiet;
    $stable(stage_select) && $stable(stage_one_ratio) &&
      $stable(stage_two_ratio) && $stable(stage_three_ratio);
  endsequence
  sequence frac_quiet;
    $stable(fraction_numerator) && $stable(fraction_denominator);
  endsequence
  a_chain_product: assert property (
    chain_quiet [*3] |-> chain_ratio == prod)
    else $error("chain ratio differs from stage product");
  a_s1_ratio_legal: assert property (
    stage_one_ratio != 4'h0 |-> (stage_one_enable || $past(stage_one_enable))
      && stage_one_ratio inside {4'h2, 4'h3})
    else $error("stage one ratio illegal or not enabled");
  a_s2_ratio_set: assert property (
    stage_two_ratio inside {4'h0, 4'h2, 4'h4, 4'h6, 4'h8})
    else $error("stage two ratio outside its set");
  a_s3_ratio_set: assert property (
    stage_three_ratio inside {4'h0, 4'h2, 4'h4, 4'h6, 4'h8})
    else $error("stage three ratio outside its set");
  a_prescale_pair: assert property (
    prescaler_ratio inside {3'h2, 3'h4})
    else $error("prescaler ratio not two or four");
  a_delay_decode: assert property (
    phase_detector_delay_valid ? phase_detector_delay_cycles inside
      {5'h04, 5'h06, 5'h08, 5'h0C, 5'h10} :
      phase_detector_delay_cycles == 5'h00)
    else $error("delay cycles disagree with valid flag");
  a_frac_valid: assert property (
    frac_quiet [*2] |-> fraction_valid == (fraction_denominator != 32'h0 &&
      fraction_numerator < fraction_denominator))
    else $error("fraction valid flag wrong");
  a_reset_values: assert property (
    $fell(rst) |-> feedback_integer == 12'h01B && prescaler_ratio == 3'h2 &&
      fraction_denominator == 32'h03E803E8 &&
      divider_to_out_a_buffer_enable && !divider_to_out_b_buffer_enable)
    else $error("reset values wrong after release");
  a_idle_hold: assert property (
    cs_n [*3] |-> $stable(divider_to_out_a_buffer_enable) &&
      $stable(divider_to_out_b_buffer_enable) && $stable(feedback_integer))
    else $error("settings moved with no frame");
endmodule // synth_cfg_assertions

// File: tb/synth_host_model.sv
// Purpose: Host serial master for the divider registers
// Assumes: Changes on falling ref_clk, sck two cycles per phase
// Notes:   Released sdi shows the inverse of its last bit
`timescale 1ns/1ps
module synth_host_model (
  input  wire logic ref_clk,
  input  wire logic sdo,
  output logic      cs_n,
  output logic      sck,
  output logic      sdi
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    sdi  = 1'b0;
  end
  // Read flag, address, data, MSB first; reply bits after rise 8
  task automatic xfer(input logic rw, input logic [6:0] addr,
                      input logic [15:0] data, output logic [15:0] rd);
    logic [23:0] f;
    f  = {rw, addr, data};
    rd = 16'h0000;
    @(negedge ref_clk) cs_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    for (int i = 0; i < 24; i++) begin
      sdi = f[23 - i];
      if (i >= 8) rd = {rd[14:0], sdo};
      sck = 1'b1;
      repeat (2) @(negedge ref_clk);
      sck = 1'b0;
      repeat (2) @(negedge ref_clk);
    end
    cs_n = 1'b1;
    sdi  = ~sdi;
    @(negedge ref_clk);
  endtask
endmodule // synth_host_model

// File: tb/synth_divider_config_regs_tb.sv
// Purpose: Register sequences over the serial port with expected values
// Assumes: Inputs change on falling ref_clk, 100 ns period
// Notes:   Reserved bits are written as zero, matching their reset, except OFF_N_INT bit 0 set by 16'h1579
`timescale 1ns/1ps
module synth_divider_config_regs_tb;
  import synth_cfg_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, sck, sdi, sdo, stage_one_enable, stage_two_enable;
  logic stage_three_enable, phase_detector_delay_valid, fraction_valid;
  logic divider_to_out_a_buffer_enable, divider_to_out_b_buffer_enable;
  logic [3:0] stage_one_ratio, stage_two_ratio, stage_three_ratio;
  logic [2:0] stage_select, prescaler_ratio;
  logic [7:0] chain_ratio;
  logic [11:0] feedback_integer;
  logic [4:0] phase_detector_delay_cycles;
  logic [31:0] fraction_numerator, fraction_denominator;
  logic [15:0] v;
  logic [3:0] cd [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
  logic [3:0] rt [5] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8};
  logic [5:0] dc [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
  logic [4:0] cy [6] = '{5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h00};
  int fail_count = 0;
  int checks = 0;
  always #50 ref_clk = ~ref_clk;
  synth_divider_config_regs i_dut (.ref_clk, .rst, .cs_n, .sck, .sdi, .sdo,
    .stage_one_ratio, .stage_two_ratio, .stage_three_ratio, .stage_one_enable,
    .stage_two_enable, .stage_three_enable, .stage_select, .chain_ratio,
    .divider_to_out_a_buffer_enable, .divider_to_out_b_buffer_enable,
    .prescaler_ratio, .feedback_integer, .phase_detector_delay_cycles,
    .phase_detector_delay_valid, .fraction_numerator, .fraction_denominator,
    .fraction_valid);
  synth_host_model i_host (.ref_clk, .sdo, .cs_n, .sck, .sdi);
  task automatic wrap_up;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    i_host.xfer(1'b0, a, d, v);
  endtask
  // Read frames carry all ones to show they write nothing
  task automatic rdc(input logic [6:0] a, input logic [15:0] e);
    i_host.xfer(1'b1, a, 16'hFFFF, v);
    chk({16'h0, v}, {16'h0, e});
  endtask
  task automatic cfg(input logic [15:0] r23, input logic [15:0] r24,
                     input logic [7:0] ec);
    wr(OFF_STAGE_CFG, r23);
    wr(OFF_SEL_DIST, r24);
    repeat (4) @(negedge ref_clk);
    chk(32'(chain_ratio), 32'(ec));
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(32'(feedback_integer), 32'h1B);
    chk(32'(prescaler_ratio), 32'h2);
    chk(fraction_denominator, 32'h03E803E8);
    chk(32'(phase_detector_delay_cycles), 32'h6);
    chk(32'({stage_three_enable, stage_two_enable,
      stage_one_enable}), 32'h0);
    rdc(OFF_STAGE_CFG, 16'h0204);
    rdc(OFF_SEL_DIST, 16'h0411);
    rdc(OFF_PRESCALE, 16'h0000);
    rdc(OFF_N_INT, 16'h0036);
    rdc(OFF_PHASE_DETECTOR_DELAY_CODE, 16'h0200);
    rdc(OFF_DEN_HI, 16'h03E8);
    rdc(OFF_DEN_LO, 16'h03E8);
    for (int i = 0; i < 5; i++) begin
      cfg({3'h0, cd[i], 6'h30, 3'h6}, {6'h02, 6'h04, cd[i]},
        8'(3 * rt[i] * rt[i]));
      chk(32'(stage_two_ratio), 32'(rt[i]));
      chk(32'(stage_three_ratio), 32'(rt[i]));
      chk(32'(stage_one_ratio), 32'h3);
      chk(32'(stage_select), 32'h4);
    end
    chk(32'({divider_to_out_b_buffer_enable,
      divider_to_out_a_buffer_enable}), 32'h2);
    cfg(16'h0582, 16'h0412, 8'h02);
    chk(32'(stage_one_ratio), 32'h2);
    cfg(16'h0582, 16'h0422, 8'h08);
    cfg(16'h0582, 16'h0402, 8'h00);
    cfg(16'h0482, 16'h0442, 8'h00);
    chk(32'(stage_three_ratio), 32'h0);
    chk(32'({stage_three_enable, stage_two_enable,
      stage_one_enable}), 32'h3);
    wr(OFF_PRESCALE, 16'h1000);
    repeat (3) @(negedge ref_clk);
    chk(32'(prescaler_ratio), 32'h4);
    wr(OFF_N_INT, 16'h1579);
    repeat (3) @(negedge ref_clk);
    chk(32'(feedback_integer), 32'hABC);
    for (int i = 0; i < 6; i++) begin
      wr(OFF_PHASE_DETECTOR_DELAY_CODE, {2'h0, dc[i], 8'h00});
      repeat (3) @(negedge ref_clk);
      chk(32'(phase_detector_delay_cycles), 32'(cy[i]));
      chk(32'(phase_detector_delay_valid), 32'(i < 5));
    end
    wr(OFF_DEN_HI, 16'h0001);
    wr(OFF_DEN_LO, 16'h0000);
    wr(OFF_NUM_LO, 16'h8000);
    repeat (3) @(negedge ref_clk);
    chk(fraction_denominator, 32'h00010000);
    chk(fraction_numerator, 32'h00008000);
    chk(32'(fraction_valid), 32'h1);
    wr(OFF_NUM_HI, 16'h0002);
    repeat (3) @(negedge ref_clk);
    chk(32'(fraction_valid), 32'h0);
    wr(7'h30, 16'hBEEF);
    rdc(7'h30, 16'h0000);
    rdc(OFF_N_INT, 16'h1579);
    rdc(OFF_PRESCALE, 16'h1000);
    wrap_up();
  end
endmodule // synth_divider_config_regs_tb
bind synth_divider_config_regs synth_cfg_assertions i_chk (.ref_clk, .rst,
  .cs_n, .stage_one_ratio, .stage_two_ratio, .stage_three_ratio,
  .stage_one_enable, .stage_select, .chain_ratio,
  .divider_to_out_a_buffer_enable, .divider_to_out_b_buffer_enable,
  .prescaler_ratio, .feedback_integer, .phase_detector_delay_cycles,
  .phase_detector_delay_valid, .fraction_numerator, .fraction_denominator,
  .fraction_valid);
